// file: spb_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module spb_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
   localparam logic [AW-1:0] LAST_IDX = AW'(D - 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp, rp;
      logic [AW:0]         cnt;
   } spb_fifo_s;

   spb_fifo_s st, nx;
   logic      push, pop;

   // Honest flags straight from the fill count
   assign inReady  = (st.cnt != FULL_CNT);
   assign outValid = (st.cnt != '0);
   assign outData  = st.mem[st.rp];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Pointer wrap is explicit since depth need not be a power of two
   always_comb begin
      nx = st;
      if (push) begin
         nx.mem[st.wp] = inData;
         nx.wp = (st.wp == LAST_IDX) ? '0 : st.wp + 1'b1;
      end
      if (pop) begin
         nx.rp = (st.rp == LAST_IDX) ? '0 : st.rp + 1'b1;
      end
      nx.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end
endmodule : spb_fifo
`default_nettype wire

// file: spb_pkg.sv
package spb_pkg;

   // Register addresses on the special function port
   localparam logic [7:0] ADDR_BAUD_CTRL = 8'h87; // power_and_baud_double_control
   localparam logic [7:0] ADDR_SER_CTRL  = 8'h98; // serial_control_status
   localparam logic [7:0] ADDR_SER_BUF   = 8'h99; // serial_buffer

   // Field positions
   localparam int BIT_BAUD_DBL = 7;
   localparam int BIT_MODE_HI  = 7;
   localparam int BIT_MODE_LO  = 6;
   localparam int BIT_MP_FILT  = 5;
   localparam int BIT_REN      = 4;
   localparam int BIT_TX_NINTH = 3;
   localparam int BIT_RX_NINTH = 2;
   localparam int BIT_TX_DONE  = 1;
   localparam int BIT_RX_DONE  = 0;

   // Mode field encodings, high bit first
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_8BIT  = 2'h1;
   localparam logic [1:0] MODE_9FIX  = 2'h2;
   localparam logic [1:0] MODE_9VAR  = 2'h3;

   // Timing counts
   localparam int         OSC_PER_M0_BIT = 12;
   localparam logic [3:0] M0_LAST    = 4'(OSC_PER_M0_BIT - 1);
   localparam logic [3:0] M0_CLK_HI  = 4'(OSC_PER_M0_BIT / 2);
   localparam logic [3:0] M0_LAST_BIT = 4'h7;
   localparam logic [3:0] OVS_LAST   = 4'hf; // 16 ticks per bit
   localparam logic [3:0] VOTE_FIRST = 4'h7;
   localparam logic [3:0] VOTE_LAST  = 4'h9;
   localparam logic [3:0] STOP_IDX8  = 4'h9;
   localparam logic [3:0] STOP_IDX9  = 4'ha;
   localparam int         FIFO_DEPTH = 8;
   localparam int         FIFO_WIDTH = 9;

   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_RUN} spb_tx_e;
   typedef enum logic {RX_IDLE, RX_RUN} spb_rx_e;

   typedef struct packed {
      logic [1:0] mode;
      logic       mpFilt, ren, txNinth, rxNinthBit, txDone, rxDone, baudDbl;
      logic [7:0] rxBuf, rdData;
      logic [2:0] rxdSync;
      logic       rxdIn, rxdPrev;
      logic [1:0] pre;
      logic       t1Tog;
      spb_tx_e    txSt;
      logic [3:0] txDiv, txBit;
      logic [10:0] txShift;
      spb_rx_e    rxSt;
      logic [3:0] rxDiv, rxBit;
      logic [1:0] votes;
      logic [7:0] rxShift;
      logic       rxNinth;
      logic       m0Act, m0IsRx;
      logic [3:0] m0Cnt, m0Bit;
      logic [7:0] m0Shift;
      logic       txd, rxdOeN;
   } spb_state_s;

   localparam spb_state_s STATE_RST = '{txSt: TX_IDLE, rxSt: RX_IDLE,
      rxdSync: 3'h7, rxdIn: 1'b1, rxdPrev: 1'b1, txd: 1'b1, rxdOeN: 1'b1,
      default: '0};

endpackage : spb_pkg

// file: spb_remote_station.sv
`timescale 1ns/1ps
`default_nettype none
module spb_remote_station (
   input  wire logic clk_sys,
   input  wire logic txd,
   input  wire logic rxdLine,
   output var logic  lineDrive
);
   // Line rests high between frames, as on a pulled-up wire
   initial lineDrive = 1'b1;

   // Start, data LSB first, optional ninth, stop; a bad stop on demand
   task automatic sendFrame(input logic [7:0] d, input logic nb, input bit has9,
                            input logic stopB, input int bitClk);
      logic [10:0] f;
      f = has9 ? {stopB, nb, d, 1'b0} : {1'b1, stopB, d, 1'b0};
      for (int i = 0; i < (has9 ? 11 : 10); i++) begin
         lineDrive = f[i];
         repeat (bitClk) @(posedge clk_sys);
         #1;
      end
      lineDrive = 1'b1;
   endtask : sendFrame

   // Mid-bit sampling, so a wrong bit rate lands samples on wrong bits
   task automatic recvFrame(input int n, input int bitClk, output logic [10:0] f);
      int w;
      f = '0;
      w = 0;
      while (txd !== 1'b0 && w < 20000) begin
         @(posedge clk_sys);
         #1;
         w++;
      end
      repeat (bitClk / 2) @(posedge clk_sys);
      #1;
      for (int i = 0; i < n; i++) begin
         f[i] = txd;
         if (i < n - 1) begin
            repeat (bitClk) @(posedge clk_sys);
            #1;
         end
      end
   endtask : recvFrame

   // Shift-clock slave: takes the data line on each rising clock
   task automatic recvShift(output logic [7:0] d, output int per);
      logic last;
      int   w;
      last = txd;
      per = 0;
      for (int i = 0; i < 8; i++) begin
         w = 0;
         while (!(txd === 1'b1 && last === 1'b0) && w < 5000) begin
            last = txd;
            @(posedge clk_sys);
            #1;
            w++;
         end
         d[i] = rxdLine;
         last = txd;
         if (i > 0) per += w;
      end
   endtask : recvShift
endmodule : spb_remote_station
`default_nettype wire

// file: spb_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module spb_serial_port (
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic [7:0] sfrAddr,
   input  wire logic       sfrWrEn,
   input  wire logic       sfrRdEn,
   input  wire logic [7:0] sfrWrData,
   output logic [7:0]      sfrRdData,
   input  wire logic       timer1Ovf,
   input  wire logic       timer2Ovf,
   input  wire logic       txUseTimer2,
   input  wire logic       rxUseTimer2,
   input  wire logic       rxd,
   output logic            rxdOut,
   output logic            rxdOe_n,
   output logic            txd,
   output logic            txQueueReady,
   output logic            serialIrq
);
   spb_pkg::spb_state_s st, nx;
   logic       wrBaud, wrCtrl, wrBuf;
   logic       m2Tick, t1Tick, txTick, rxTick, txBound;
   logic       fifoOutValid, fifoOutReady, pop;
   logic [8:0] fifoOutData;
   logic       maj, rxFin, rxOk, isAsync;
   logic [3:0] stopIdx;

   // Port decode
   assign wrBaud = sfrWrEn && (sfrAddr == spb_pkg::ADDR_BAUD_CTRL);
   assign wrCtrl = sfrWrEn && (sfrAddr == spb_pkg::ADDR_SER_CTRL);
   assign wrBuf  = sfrWrEn && (sfrAddr == spb_pkg::ADDR_SER_BUF);
   assign isAsync = (st.mode != spb_pkg::MODE_SHIFT);
   assign stopIdx = st.mode[1] ? spb_pkg::STOP_IDX9 : spb_pkg::STOP_IDX8;

   // Sixteen-times ticks; timers are same-clock pulses, no sync needed
   assign m2Tick = st.baudDbl ? st.pre[0] : (st.pre == 2'h3);
   assign t1Tick = timer1Ovf && (st.baudDbl || st.t1Tog);
   assign txTick = (st.mode == spb_pkg::MODE_9FIX) ? m2Tick
                 : (txUseTimer2 ? timer2Ovf : t1Tick);
   assign rxTick = (st.mode == spb_pkg::MODE_9FIX) ? m2Tick
                 : (rxUseTimer2 ? timer2Ovf : t1Tick);
   assign txBound = txTick && (st.txDiv == spb_pkg::OVS_LAST);

   // Transmit queue keeps back-to-back buffer writes
   assign fifoOutReady = isAsync ? (st.txSt == spb_pkg::TX_IDLE) : !st.m0Act;
   assign pop = fifoOutValid && fifoOutReady;

   spb_fifo #(
      .W(spb_pkg::FIFO_WIDTH),
      .D(spb_pkg::FIFO_DEPTH)
   ) u_txq (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .inValid  (wrBuf),
      .inReady  (txQueueReady),
      .inData   ({st.txNinth, sfrWrData}),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   // Two of three votes at the mid-bit samples
   assign maj = (st.votes[1] & st.votes[0]) | (st.votes[1] & st.rxdIn)
              | (st.votes[0] & st.rxdIn);
   assign rxFin = (st.rxSt == spb_pkg::RX_RUN) && st.ren && rxTick
               && (st.rxDiv == spb_pkg::VOTE_LAST) && (st.rxBit == stopIdx);
   // Filter: ninth bit in 9-bit modes, stop bit in mode 1
   assign rxOk = !st.rxDone && (!st.mpFilt || (st.mode[1] ? st.rxNinth : maj));

   // Outputs straight from state
   assign sfrRdData = st.rdData;
   assign rxdOut    = st.m0Shift[0];
   assign rxdOe_n   = st.rxdOeN;
   assign txd       = st.txd;
   assign serialIrq = st.txDone || st.rxDone;

   // Next-state logic; hardware flag sets come last so they win
   always_comb begin
      nx = st;
      // Only the second and third stages are compared
      nx.rxdSync = {st.rxdSync[1:0], rxd};
      if (st.rxdSync[1] == st.rxdSync[2]) begin
         nx.rxdIn = st.rxdSync[2];
      end
      nx.rxdPrev = st.rxdIn;
      nx.pre = st.pre + 2'h1;
      if (timer1Ovf) begin
         nx.t1Tog = !st.t1Tog;
      end

      // Software writes
      if (wrBaud) begin
         nx.baudDbl = sfrWrData[spb_pkg::BIT_BAUD_DBL];
      end
      if (wrCtrl) begin
         nx.mode = {sfrWrData[spb_pkg::BIT_MODE_HI], sfrWrData[spb_pkg::BIT_MODE_LO]};
         nx.mpFilt     = sfrWrData[spb_pkg::BIT_MP_FILT];
         nx.ren        = sfrWrData[spb_pkg::BIT_REN];
         nx.txNinth    = sfrWrData[spb_pkg::BIT_TX_NINTH];
         nx.rxNinthBit = sfrWrData[spb_pkg::BIT_RX_NINTH];
         nx.txDone     = sfrWrData[spb_pkg::BIT_TX_DONE];
         nx.rxDone     = sfrWrData[spb_pkg::BIT_RX_DONE];
      end

      // Reads land one cycle later; unmapped reads give zero
      if (sfrRdEn) begin
         case (sfrAddr)
            spb_pkg::ADDR_BAUD_CTRL: nx.rdData = {st.baudDbl, 7'h00};
            spb_pkg::ADDR_SER_CTRL:  nx.rdData = {st.mode, st.mpFilt, st.ren,
                                                  st.txNinth, st.rxNinthBit,
                                                  st.txDone, st.rxDone};
            spb_pkg::ADDR_SER_BUF:   nx.rdData = st.rxBuf;
            default:                nx.rdData = 8'h00;
         endcase
      end

      // Mode 0 shift engine, one bit per twelve oscillator clocks
      if (st.m0Act) begin
         nx.m0Cnt = (st.m0Cnt == spb_pkg::M0_LAST) ? 4'h0 : st.m0Cnt + 4'h1;
         if (st.m0Cnt == spb_pkg::M0_LAST) begin
            nx.m0Shift = {st.m0IsRx & st.rxdIn, st.m0Shift[7:1]};
            nx.m0Bit = st.m0Bit + 4'h1;
            if (st.m0Bit == spb_pkg::M0_LAST_BIT) begin
               nx.m0Act = 1'b0;
               if (st.m0IsRx) begin
                  nx.rxBuf = nx.m0Shift;
                  nx.rxDone = 1'b1;
               end else begin
                  nx.txDone = 1'b1;
               end
            end
         end
      end else if (!isAsync) begin
         if (fifoOutValid) begin
            nx.m0Act = 1'b1;
            nx.m0IsRx = 1'b0;
            nx.m0Shift = fifoOutData[7:0];
            nx.m0Cnt = 4'h0;
            nx.m0Bit = 4'h0;
         end else if (st.ren && !st.rxDone) begin
            nx.m0Act = 1'b1;
            nx.m0IsRx = 1'b1;
            nx.m0Shift = 8'h00;
            nx.m0Cnt = 4'h0;
            nx.m0Bit = 4'h0;
         end
      end

      // Asynchronous transmitter; bit times follow the divide counter
      if (txTick) begin
         nx.txDiv = st.txDiv + 4'h1;
      end
      case (st.txSt)
         spb_pkg::TX_IDLE: begin
            if (isAsync && fifoOutValid) begin
               // Start 0, data LSB first, ninth or stop, stop 1
               nx.txShift = {1'b1, st.mode[1] ? fifoOutData[8] : 1'b1,
                             fifoOutData[7:0], 1'b0};
               nx.txSt = spb_pkg::TX_WAIT;
            end
         end
         spb_pkg::TX_WAIT: begin
            if (txBound) begin
               nx.txSt = spb_pkg::TX_RUN;
               nx.txBit = 4'h0;
            end
         end
         spb_pkg::TX_RUN: begin
            if (txBound) begin
               if (st.txBit == stopIdx) begin
                  nx.txSt = spb_pkg::TX_IDLE;
               end else begin
                  nx.txShift = {1'b1, st.txShift[10:1]};
                  nx.txBit = st.txBit + 4'h1;
                  if (st.txBit + 4'h1 == stopIdx) begin
                     nx.txDone = 1'b1;
                  end
               end
            end
         end
         default: nx.txSt = spb_pkg::TX_IDLE;
      endcase

      // Asynchronous receiver with false start rejection
      case (st.rxSt)
         spb_pkg::RX_IDLE: begin
            if (isAsync && st.ren && st.rxdPrev && !st.rxdIn) begin
               nx.rxSt = spb_pkg::RX_RUN;
               nx.rxDiv = 4'h0;
               nx.rxBit = 4'h0;
            end
         end
         spb_pkg::RX_RUN: begin
            if (!st.ren || !isAsync) begin
               nx.rxSt = spb_pkg::RX_IDLE;
            end else if (rxTick) begin
               nx.rxDiv = st.rxDiv + 4'h1;
               if (st.rxDiv >= spb_pkg::VOTE_FIRST && st.rxDiv < spb_pkg::VOTE_LAST) begin
                  nx.votes = {st.votes[0], st.rxdIn};
               end
               if (st.rxDiv == spb_pkg::VOTE_LAST) begin
                  if (st.rxBit == 4'h0) begin
                     if (maj) begin
                        nx.rxSt = spb_pkg::RX_IDLE;
                     end
                  end else if (st.rxBit <= 4'h8) begin
                     nx.rxShift = {maj, st.rxShift[7:1]};
                  end else if (st.rxBit != stopIdx) begin
                     nx.rxNinth = maj;
                  end else begin
                     nx.rxSt = spb_pkg::RX_IDLE;
                  end
               end
               if (st.rxDiv == spb_pkg::OVS_LAST) begin
                  nx.rxBit = st.rxBit + 4'h1;
               end
            end
         end
         default: nx.rxSt = spb_pkg::RX_IDLE;
      endcase
      if (rxFin && rxOk) begin
         nx.rxBuf = st.rxShift;
         nx.rxNinthBit = st.mode[1] ? st.rxNinth : maj;
         nx.rxDone = 1'b1;
      end

      // Pin drivers; shift clock low in the first half of each bit
      nx.txd = nx.m0Act ? (nx.m0Cnt >= spb_pkg::M0_CLK_HI)
             : ((nx.txSt == spb_pkg::TX_RUN) ? nx.txShift[0] : 1'b1);
      nx.rxdOeN = !(nx.m0Act && !nx.m0IsRx);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= spb_pkg::STATE_RST;
      end else begin
         st <= nx;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   property p_tiAtStop;
      (st.txSt == spb_pkg::TX_RUN) && txBound && (st.txBit + 4'h1 == stopIdx)
         |=> st.txDone && txd;
   endproperty
   a_tiAtStop: assert property (p_tiAtStop) else $error("tx done not at stop");

   property p_filter9;
      rxFin && st.mode[1] && st.mpFilt && !st.rxNinth && !st.rxDone && !wrCtrl
         |=> !st.rxDone;
   endproperty
   a_filter9: assert property (p_filter9) else $error("ninth bit filter failed");

   property p_filterStop;
      rxFin && (st.mode == spb_pkg::MODE_8BIT) && st.mpFilt && !maj && !st.rxDone && !wrCtrl
         |=> !st.rxDone;
   endproperty
   a_filterStop: assert property (p_filterStop) else $error("stop filter failed");

   property p_renOff;
      !st.ren && isAsync |=> st.rxSt == spb_pkg::RX_IDLE;
   endproperty
   a_renOff: assert property (p_renOff) else $error("receiver ran while off");

   property p_m0Clock;
      st.m0Act && (st.m0Cnt == 4'h0) && (st.m0Bit != spb_pkg::M0_LAST_BIT)
         |-> !txd ##6 txd ##6 !txd;
   endproperty
   a_m0Clock: assert property (p_m0Clock) else $error("mode 0 clock period");

   property p_m0Drive;
      st.m0Act && !st.m0IsRx |-> !rxdOe_n;
   endproperty
   a_m0Drive: assert property (p_m0Drive) else $error("mode 0 data not driven");

   property p_m2Slow;
      // A doubling write just after the tick legally speeds the next ones
      m2Tick && !st.baudDbl && !wrBaud |=> (!m2Tick || st.baudDbl) [*3];
   endproperty
   a_m2Slow: assert property (p_m2Slow) else $error("mode 2 tick too fast");

   property p_sendStart;
      wrBuf && txQueueReady |=> fifoOutValid || st.m0Act
         || (st.txSt != spb_pkg::TX_IDLE);
   endproperty
   a_sendStart: assert property (p_sendStart) else $error("write did not queue");

   property p_m0RxStart;
      !isAsync && !st.m0Act && st.ren && !st.rxDone && !fifoOutValid && !wrCtrl
         |=> st.m0Act && st.m0IsRx;
   endproperty
   a_m0RxStart: assert property (p_m0RxStart) else $error("mode 0 rx not started");

   c_txAsync: cover property (st.txSt == spb_pkg::TX_RUN && txBound && st.txBit == stopIdx);
   c_rxAsync: cover property (rxFin && rxOk);
   c_m0Rx: cover property (st.m0Act && st.m0IsRx && st.m0Bit == spb_pkg::M0_LAST_BIT);
   c_queueFull: cover property (!txQueueReady);
endmodule : spb_serial_port
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int         T1P  = 4;
   localparam int         T2P  = 3;
   localparam logic [7:0] aBaud = spb_pkg::ADDR_BAUD_CTRL;
   localparam logic [7:0] aCtrl = spb_pkg::ADDR_SER_CTRL;
   localparam logic [7:0] aBuf  = spb_pkg::ADDR_SER_BUF;
   logic        clk_sys, nrst, sfrWrEn, sfrRdEn, timer1Ovf, timer2Ovf;
   logic        txUseTimer2, rxUseTimer2;
   logic [7:0]  sfrAddr, sfrWrData, rd;
   logic [10:0] raw;
   logic [7:0]  regs [4];
   wire logic [7:0] sfrRdData;
   wire logic   rxd, rxdOut, rxdOe_n, txd, txQueueReady, serialIrq, lineDrive;
   int          nMismatch, numChecks, t1Cnt, t2Cnt, per;

   spb_serial_port uut (.clk_sys(clk_sys), .nrst(nrst), .sfrAddr(sfrAddr),
      .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData),
      .sfrRdData(sfrRdData), .timer1Ovf(timer1Ovf), .timer2Ovf(timer2Ovf),
      .txUseTimer2(txUseTimer2), .rxUseTimer2(rxUseTimer2), .rxd(rxd),
      .rxdOut(rxdOut), .rxdOe_n(rxdOe_n), .txd(txd),
      .txQueueReady(txQueueReady), .serialIrq(serialIrq));
   spb_remote_station rem (.clk_sys(clk_sys), .txd(txd), .rxdLine(rxd),
      .lineDrive(lineDrive));

   // Shared data pin: the port wins only while its enable is low
   assign rxd = (rxdOe_n == 1'b0) ? rxdOut : lineDrive;

   always #12.5 clk_sys = ~clk_sys;

   // Overflow pulses only; the timers' own interrupts are not modelled
   always @(posedge clk_sys) begin
      #1;
      t1Cnt = (t1Cnt + 1) % T1P;
      t2Cnt = (t2Cnt + 1) % T2P;
      timer1Ovf = (t1Cnt == 0);
      timer2Ovf = (t2Cnt == 0);
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      numChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One strobe cycle, then released; each access starts off an edge
   task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      sfrAddr = a;
      sfrWrData = d;
      sfrWrEn = 1'b1;
      @(posedge clk_sys);
      #1;
      sfrWrEn = 1'b0;
   endtask : wrReg

   task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1;
      sfrAddr = a;
      sfrRdEn = 1'b1;
      @(posedge clk_sys);
      #1;
      sfrRdEn = 1'b0;
      @(posedge clk_sys);
      #1;
      d = sfrRdData;
   endtask : rdReg

   // Remote sends one frame; status and, if accepted, buffer compared
   task automatic rxCase(input logic [7:0] ctrl, input logic [7:0] dat, input logic nb,
                         input bit has9, input logic stopB, input int bitClk,
                         input logic [7:0] expCtrl);
      logic [7:0] r;
      wrReg(aCtrl, ctrl);
      rem.sendFrame(dat, nb, has9, stopB, bitClk);
      rdReg(aCtrl, r);
      chk(r, expCtrl);
      if (expCtrl[0]) begin
         rdReg(aBuf, r);
         chk(r, dat);
      end
   endtask : rxCase

   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // Run is near 12000 cycles; far beyond that means a hang
   initial begin
      repeat (40000) @(posedge clk_sys);
      nMismatch++;
      $display("CHECK FAILED t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
      print_verdict();
   end

   initial begin
      clk_sys = 1'b0;
      nrst = 1'b0;
      {sfrWrEn, sfrRdEn, timer1Ovf, timer2Ovf, txUseTimer2, rxUseTimer2} = '0;
      sfrAddr = '0;
      sfrWrData = '0;
      {t1Cnt, t2Cnt, nMismatch, numChecks} = '0;
      regs = '{aBaud, aCtrl, aBuf, 8'h55};
      repeat (16) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      // Reset levels, then all registers and an unmapped place read zero
      chk({txd, serialIrq, rxdOe_n, txQueueReady}, 4'hb);
      for (int i = 0; i < 4; i++) begin
         rdReg(regs[i], rd);
         chk(rd, 8'h00);
      end
      wrReg(aBaud, 8'hff);
      rdReg(aBaud, rd);
      chk(rd, 8'h80);
      wrReg(aBaud, 8'h00);
      wrReg(8'h55, 8'hff);
      rdReg(aCtrl, rd);
      chk(rd, 8'h00);
      // Mode 0 send: clock on txd, data on the shared pin
      fork
         rem.recvShift(raw[7:0], per);
         wrReg(aBuf, 8'h3c);
      join
      chk(raw[7:0], 8'h3c);
      chk(16'(per), 16'd84);
      // Last rising clock is mid-bit; the flag comes at the end of the bit
      repeat (8) @(posedge clk_sys);
      #1;
      rdReg(aCtrl, rd);
      chk(rd, 8'h02);
      chk(serialIrq, 1'b1);
      // Mode 0 receive starts on its own; idle-high pin gives all ones
      wrReg(aCtrl, 8'h10);
      repeat (130) @(posedge clk_sys);
      rdReg(aCtrl, rd);
      chk(rd, 8'h11);
      rdReg(aBuf, rd);
      chk(rd, 8'hff);
      wrReg(aCtrl, 8'h00);
      chk(serialIrq, 1'b0);
      // Mode 2 at both rates, ninth bit both ways
      for (int m = 0; m < 2; m++) begin
         wrReg(aBaud, m ? 8'h80 : 8'h00);
         wrReg(aCtrl, m ? 8'h80 : 8'h88);
         fork
            rem.recvFrame(11, m ? 32 : 64, raw);
            wrReg(aBuf, 8'ha5);
         join
         chk(raw, {1'b1, m == 0, 8'ha5, 1'b0});
         rdReg(aCtrl, rd);
         chk(rd, m ? 8'h82 : 8'h8a);
      end
      // Receive: filter in modes 3 and 1, receiver off, timer 2 source
      wrReg(aBaud, 8'h00);
      rxCase(8'hf0, 8'h5a, 1'b0, 1, 1'b1, 32 * T1P, 8'hf0);
      rxCase(8'hf0, 8'h5a, 1'b1, 1, 1'b1, 32 * T1P, 8'hf5);
      wrReg(aBaud, 8'h80);
      rxCase(8'h70, 8'h33, 1'b0, 0, 1'b0, 16 * T1P, 8'h70);
      rxCase(8'h70, 8'h33, 1'b0, 0, 1'b1, 16 * T1P, 8'h75);
      rxCase(8'h40, 8'h33, 1'b0, 0, 1'b1, 16 * T1P, 8'h40);
      rxUseTimer2 = 1'b1;
      rxCase(8'hd0, 8'h81, 1'b0, 1, 1'b1, 16 * T2P, 8'hd1);
      // Queue fill: ten writes back to back, the tenth must be dropped
      txUseTimer2 = 1'b1;
      wrReg(aCtrl, 8'h40);
      fork
         begin
            @(posedge clk_sys);
            #1;
            sfrAddr = aBuf;
            sfrWrEn = 1'b1;
            for (int i = 0; i < 10; i++) begin
               if (i == 9) chk(txQueueReady, 1'b0);
               sfrWrData = 8'(16 + i);
               @(posedge clk_sys);
               #1;
            end
            sfrWrEn = 1'b0;
         end
         for (int k = 0; k < 9; k++) begin
            rem.recvFrame(10, 16 * T2P, raw);
            chk(raw, {2'b01, 8'(16 + k), 1'b0});
         end
      join
      per = 0;
      repeat (600) begin
         @(posedge clk_sys);
         #1;
         if (txd !== 1'b1) per++;
      end
      chk(16'(per), 16'd0);
      chk(txQueueReady, 1'b1);
      rdReg(aCtrl, rd);
      chk(rd, 8'h42);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
